// [rtl/iopcb_port.sv]
// port with serialiser, 16-word fifo, port counter, timestamp and six clock blocks
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module iopcb_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;

    always_comb begin
        in_ready    = (wr_ptr - rd_ptr) != (AW + 1)'(DEPTH);
        out_valid   = wr_ptr != rd_ptr;
        push        = in_valid && in_ready;
        pop         = out_valid && out_ready;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        out_data    = mem[rd_ptr[AW-1:0]];
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // storage needs no reset; valid is governed by the pointers
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    fifo_full_a: assert property (@(posedge core_clk) disable iff (reset)
        (wr_ptr - rd_ptr) == (AW + 1)'(DEPTH) |-> !in_ready && out_valid)
        else $error("fifo accepts while full");
endmodule // iopcb_fifo

////////////////////////////////////////////////////////////////////////////////
// Function
// - port widths 1, 4, 8, 16, 32; one direction
// - no mixed directions within one port
// - drive pins or sample, optionally on condition
// - each processor access completes in one cycle
// - open collector: zero pulls low, one floats
// - open collector chosen per port
// - data passes serialiser and transfer fifo
// - sixteen-bit port counter governs transfer moment
// - counter readable; transfer deferrable to counter value
// - transfer captures counter as timestamp
// - enabled link disables port pins
// - narrower port wins over shared wider pins
// - port always transfers at nominal width
// - six clock blocks; block zero 100 MHz
// - clock block may use divided external clock
// - strobe in qualifies input; strobe out
// - after reset port uses clock block zero
// - pull-downs enabled while in reset
// - pin events go straight to scheduler
// - enabling port switches pull off; software override
module iopcb_port #(
    parameter int PORT_W = iopcb_pkg::PORT_W_DEF
) (
    // clock and reset
    input  wire logic                                      core_clk,
    input  wire logic                                      reset,
    // port configuration
    input  wire logic                                      port_enable,
    input  wire logic                                      dir_out,
    input  wire logic                                      link_enable,
    input  wire logic [PORT_W-1:0]                         narrow_claim,
    input  wire logic                                      cfg_write,
    input  wire logic                                      cfg_open_collector,
    input  wire logic [iopcb_pkg::CLKSEL_W-1:0]            cfg_clk_sel,
    input  wire iopcb_pkg::iopcb_cond_t                    cond_mode,
    input  wire logic [PORT_W-1:0]                         cond_value,
    input  wire logic                                      strobe_in_enable,
    input  wire logic                                      pull_write,
    input  wire logic [PORT_W-1:0]                         pull_value,
    // clock blocks
    input  wire logic [iopcb_pkg::NUM_CLKBLK-1:0]          cb_ext_sel,
    input  wire logic [iopcb_pkg::NUM_CLKBLK*iopcb_pkg::CLKDIV_W-1:0] cb_div,
    // timed transfer
    input  wire logic                                      timed_arm,
    input  wire logic [iopcb_pkg::CNT_W-1:0]               timed_value,
    // processor write
    input  wire logic                                      cpu_wr_valid,
    output logic                                           cpu_wr_ready,
    input  wire logic [iopcb_pkg::XFER_W-1:0]              cpu_wr_data,
    // processor read
    output logic                                           cpu_rd_valid,
    input  wire logic                                      cpu_rd_ready,
    output logic [iopcb_pkg::XFER_W-1:0]                   cpu_rd_data,
    // status and events
    output logic [iopcb_pkg::CNT_W-1:0]                    port_count,
    output logic [iopcb_pkg::CNT_W-1:0]                    port_stamp,
    output logic                                           timed_pending,
    output logic                                           cond_event,
    output logic [iopcb_pkg::CLKSEL_W-1:0]                 clk_sel,
    output logic                                           open_collector,
    // pins
    input  wire logic [PORT_W-1:0]                         pin_in,
    output logic [PORT_W-1:0]                              pin_out,
    output logic [PORT_W-1:0]                              pin_oe,
    output logic [PORT_W-1:0]                              pin_pull_down,
    input  wire logic                                      ext_clk_in,
    input  wire logic                                      strobe_in,
    output logic                                           strobe_out
);
    localparam int XW    = iopcb_pkg::XFER_W;
    localparam int CW    = iopcb_pkg::CNT_W;
    localparam int NCB   = iopcb_pkg::NUM_CLKBLK;
    localparam int DW    = iopcb_pkg::CLKDIV_W;
    localparam int BEATS = XW / PORT_W;
    localparam int RW    = (BEATS > 1) ? $clog2(BEATS) : 1;
    localparam int SW    = PORT_W + 2;
    localparam int RCW   = (iopcb_pkg::REF_DIV > 1) ? $clog2(iopcb_pkg::REF_DIV) : 1;

    if (PORT_W != 1 && PORT_W != 4 && PORT_W != 8 && PORT_W != 16 && PORT_W != 32) begin : g_chk
        $error("port width must be 1, 4, 8, 16 or 32");
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a bit changes once stages two and three agree
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic [SW-1:0] sync3;
    logic [SW-1:0] filt;
    logic [SW-1:0] next_filt;
    logic          ext_prev;
    logic          ext_rise;

    always_comb begin
        next_filt = (sync3 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
        ext_rise  = filt[SW-1] && !ext_prev;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sync1    <= '0;
            sync2    <= '0;
            sync3    <= '0;
            filt     <= '0;
            ext_prev <= 1'b0;
        end else begin
            sync1    <= {ext_clk_in, strobe_in, pin_in};
            sync2    <= sync1;
            sync3    <= sync2;
            filt     <= next_filt;
            ext_prev <= filt[SW-1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock blocks: block zero is the reference, others divide ref or ext pin
    logic [RCW-1:0] ref_cnt;
    logic [RCW-1:0] next_ref_cnt;
    logic           ref_tick;
    logic [NCB-1:0] cb_tick;

    always_comb begin
        ref_tick     = ref_cnt == RCW'(iopcb_pkg::REF_DIV - 1);
        next_ref_cnt = ref_tick ? '0 : ref_cnt + 1'b1;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ref_cnt <= '0;
        end else begin
            ref_cnt <= next_ref_cnt;
        end
    end

    for (genvar k = 0; k < NCB; k++) begin : g_cb
        logic [DW-1:0] cnt;
        logic [DW-1:0] next_cnt;
        logic          src;
        logic [DW-1:0] div;
        always_comb begin
            src        = (k == 0 || !cb_ext_sel[k]) ? ref_tick : ext_rise;
            div        = (k == 0) ? '0 : cb_div[k*DW +: DW];
            cb_tick[k] = src && cnt == div;
            next_cnt   = cnt;
            if (src) begin
                next_cnt = (cnt == div) ? '0 : cnt + 1'b1;
            end
        end
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                cnt <= '0;
            end else begin
                cnt <= next_cnt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // port state
    logic                active;
    logic                tick;
    logic                time_ok;
    logic                cond_ok;
    logic [PORT_W-1:0]   pins_eff;
    logic                sample;
    logic                pop;
    logic                hold;
    logic [XW-1:0]       shreg;
    logic [RW-1:0]       remain;
    logic [PORT_W-1:0]   drive;
    logic                enable_prev;
    logic                next_hold;
    logic [XW-1:0]       next_shreg;
    logic [RW-1:0]       next_remain;
    logic [PORT_W-1:0]   next_drive;
    logic [CW-1:0]       next_count;
    logic [CW-1:0]       next_stamp;
    logic                next_pending;
    logic [CW-1:0]       target;
    logic [CW-1:0]       next_target;
    logic                next_strobe_out;
    logic                next_cond_event;
    logic [PORT_W-1:0]   next_pull;
    logic [iopcb_pkg::CLKSEL_W-1:0] next_clk_sel;
    logic                next_oc;
    logic                fifo_in_valid;
    logic                fifo_in_ready;
    logic [XW-1:0]       fifo_in_data;
    logic                fifo_out_valid;
    logic                fifo_out_ready;

    always_comb begin
        active   = port_enable && !link_enable;
        tick     = active && clk_sel < iopcb_pkg::CLKSEL_W'(NCB) && cb_tick[clk_sel];
        time_ok  = !timed_pending || port_count == target;
        pins_eff = filt[PORT_W-1:0] & ~narrow_claim;
        unique case (cond_mode)
            iopcb_pkg::COND_EQ: cond_ok = pins_eff == cond_value;
            iopcb_pkg::COND_NE: cond_ok = pins_eff != cond_value;
            default:            cond_ok = 1'b1;
        endcase
        pop    = tick && dir_out && remain == '0 && fifo_out_valid && time_ok;
        sample = tick && !dir_out && !hold && cond_ok && (remain != '0 || time_ok)
                 && (!strobe_in_enable || filt[SW-2]);

        next_count      = tick ? port_count + 1'b1 : port_count;
        next_stamp      = port_stamp;
        next_pending    = timed_pending;
        next_target     = target;
        next_shreg      = shreg;
        next_remain     = remain;
        next_drive      = drive;
        next_strobe_out = strobe_out;
        next_hold       = hold && !fifo_in_ready;
        next_cond_event = tick && !dir_out && cond_mode != iopcb_pkg::COND_NONE && cond_ok;
        next_clk_sel    = cfg_write ? cfg_clk_sel : clk_sel;
        next_oc         = cfg_write ? cfg_open_collector : open_collector;
        next_pull       = pin_pull_down;
        if (port_enable && !enable_prev) begin
            next_pull = '0;
        end
        if (pull_write) begin
            next_pull = pull_value;
        end

        if (tick && dir_out) begin
            if (remain != '0) begin
                next_drive  = shreg[PORT_W-1:0];
                next_shreg  = shreg >> PORT_W;
                next_remain = remain - 1'b1;
            end else if (pop) begin
                next_drive      = cpu_rd_data[PORT_W-1:0];
                next_shreg      = cpu_rd_data >> PORT_W;
                next_remain     = RW'(BEATS - 1);
                next_stamp      = port_count;
                next_pending    = 1'b0;
                next_strobe_out = 1'b1;
            end else begin
                next_strobe_out = 1'b0;
            end
        end
        if (sample) begin
            next_shreg = (shreg >> PORT_W) | (XW'(pins_eff) << (XW - PORT_W));
            if (remain == RW'(BEATS - 1)) begin
                next_remain  = '0;
                next_hold    = 1'b1;
                next_stamp   = port_count;
                next_pending = 1'b0;
            end else begin
                next_remain = remain + 1'b1;
            end
        end
        // a new arm in the transfer cycle wins, so the next transfer waits again
        if (timed_arm) begin
            next_pending = 1'b1;
            next_target  = timed_value;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            port_count     <= iopcb_pkg::CNT_RESET;
            port_stamp     <= iopcb_pkg::CNT_RESET;
            timed_pending  <= 1'b0;
            target         <= iopcb_pkg::CNT_RESET;
            shreg          <= '0;
            remain         <= '0;
            drive          <= '0;
            hold           <= 1'b0;
            strobe_out     <= 1'b0;
            cond_event     <= 1'b0;
            clk_sel        <= iopcb_pkg::CLKSEL_RESET;
            open_collector <= iopcb_pkg::OC_RESET;
            pin_pull_down  <= {PORT_W{iopcb_pkg::PULL_RESET}};
            enable_prev    <= 1'b0;
        end else begin
            port_count     <= next_count;
            port_stamp     <= next_stamp;
            timed_pending  <= next_pending;
            target         <= next_target;
            shreg          <= next_shreg;
            remain         <= next_remain;
            drive          <= next_drive;
            hold           <= next_hold;
            strobe_out     <= next_strobe_out;
            cond_event     <= next_cond_event;
            clk_sel        <= next_clk_sel;
            open_collector <= next_oc;
            pin_pull_down  <= next_pull;
            enable_prev    <= port_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fifo sides swap with direction; turning round with data inside mixes words
    always_comb begin
        fifo_in_valid  = dir_out ? cpu_wr_valid : hold;
        fifo_in_data   = dir_out ? cpu_wr_data : shreg;
        fifo_out_ready = dir_out ? pop : cpu_rd_ready;
        cpu_wr_ready   = dir_out && fifo_in_ready;
        cpu_rd_valid   = !dir_out && fifo_out_valid;
        pin_out        = open_collector ? '0 : drive;
        pin_oe         = (active && dir_out) ? ((open_collector ? ~drive : '1) & ~narrow_claim) : '0;
    end

    iopcb_fifo #(
        .WIDTH (XW),
        .DEPTH (iopcb_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .reset     (reset),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (cpu_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb_main @(posedge core_clk); endclocking
    default disable iff (reset);

    one_direction_a: assert property ((|pin_oe) |-> dir_out && port_enable)
        else $error("pins driven while port is input or disabled");
    open_drain_a: assert property (open_collector |-> pin_out == '0 && (pin_oe & drive) == '0)
        else $error("open collector drives a one");
    link_owns_a: assert property (link_enable |-> pin_oe == '0)
        else $error("port drives pins owned by link");
    narrow_wins_a: assert property ((pin_oe & narrow_claim) == '0)
        else $error("wider port drives claimed pin");
    counter_step_a: assert property (tick |=> port_count == $past(port_count) + 1'b1)
        else $error("port counter did not advance on tick");
    stamp_take_a: assert property (pop |=> port_stamp == $past(port_count) && strobe_out)
        else $error("timestamp or strobe missing after transfer");
    timed_hold_a: assert property (pop && timed_pending |-> port_count == target)
        else $error("timed transfer before counter match");
    pull_release_a: assert property (port_enable && !enable_prev && !pull_write |=> pin_pull_down == '0)
        else $error("pull stays on after enable");
    read_single_a: assert property (cpu_rd_valid && cpu_rd_ready |=> !$stable(u_fifo.rd_ptr))
        else $error("processor read not taken in one cycle");
endmodule // iopcb_port

// [rtl/iopcb_pkg.sv]
// shared constants and types for the hardware-response port and its clock blocks
package iopcb_pkg;
    // clocking
    localparam int unsigned CORE_HZ     = 200_000_000;
    localparam int unsigned REF_HZ      = 100_000_000;
    localparam int unsigned REF_DIV     = CORE_HZ / REF_HZ;
    localparam int unsigned NUM_CLKBLK  = 6;
    localparam int unsigned CLKDIV_W    = 8;
    localparam int unsigned CLKSEL_W    = 3;
    // data path
    localparam int unsigned CNT_W       = 16;
    localparam int unsigned XFER_W      = 32;
    localparam int unsigned FIFO_DEPTH  = 16;
    localparam int unsigned PORT_W_DEF  = 32;
    // reset values
    localparam logic [2:0] CLKSEL_RESET = 3'h0;
    localparam logic       OC_RESET     = 1'b0;
    localparam logic       PULL_RESET   = 1'b1;
    localparam logic [15:0] CNT_RESET   = 16'h0000;

    // pin condition that input sampling waits for
    typedef enum logic [1:0] {
        COND_NONE,
        COND_EQ,
        COND_NE
    } iopcb_cond_t;
endpackage

// [verification/iopcb_pins_model.sv]
// far-side model: wire levels of the port pins, incoming strobe and an external clock
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module iopcb_pins_model #(
    parameter int W = 32
) (
    // clock
    input  wire logic         core_clk,
    // port side
    input  wire logic [W-1:0] pin_out,
    input  wire logic [W-1:0] pin_oe,
    input  wire logic [W-1:0] pin_pull_down,
    // bench control
    input  wire logic         drive_en,
    input  wire logic [W-1:0] drive_val,
    input  wire logic         pull_up,
    // wire levels
    output logic [W-1:0]      pin_in,
    output logic              strobe_in,
    output logic              ext_clk_in
);
    logic [W-1:0] noise = 32'h5a5a_c3c3;

    // floating lines wander so a stale value never passes for data
    always @(posedge core_clk) noise <= ~noise;

    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (drive_en)
                pin_in[i] = drive_val[i];
            else if (pull_up)
                pin_in[i] = 1'b1;
            else if (pin_pull_down[i])
                pin_in[i] = 1'b0;
            else
                pin_in[i] = noise[i];
        end
    end

    // data is presented only together with the strobe
    assign strobe_in = drive_en;

    initial ext_clk_in = 1'b0;

    // the external clock stands low between bursts
    // each level lasts three core cycles, so the pin filter never drops it
    task automatic pulse_ext(input int n);
        repeat (n) begin
            #15 ext_clk_in = 1'b1;
            #15 ext_clk_in = 1'b0;
        end
    endtask
endmodule // iopcb_pins_model

// [verification/tb_top.sv]
// self-checking bench of the port: expected-result queue and an output watcher
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module tb_top;
    // design inputs
    logic        core_clk = 1'b0, reset = 1'b1, port_enable = 1'b0, dir_out = 1'b1, link_enable = 1'b1;
    logic        cfg_write = 1'b0, cfg_open_collector = 1'b0, strobe_in_enable = 1'b1, pull_write = 1'b0;
    logic        timed_arm = 1'b0, cpu_wr_valid = 1'b0, cpu_rd_ready = 1'b0, drive_en = 1'b0, pull_up = 1'b0;
    logic [2:0]  cfg_clk_sel = 3'h0;
    logic [5:0]  cb_ext_sel = 6'h02;
    logic [47:0] cb_div = 48'h0000_0000_0100;
    logic [15:0] timed_value = 16'h0000, tv, c0;
    logic [31:0] narrow_claim = 32'h0, cond_value = 32'h0, pull_value = 32'h0, cpu_wr_data = 32'h0;
    logic [31:0] drive_val = 32'h0, v;
    iopcb_pkg::iopcb_cond_t cond_mode = iopcb_pkg::COND_NONE;
    // design outputs and wire levels
    logic        cpu_wr_ready, cpu_rd_valid, timed_pending, cond_event, open_collector, strobe_out;
    logic        strobe_in, ext_clk_in, last_strobe;
    logic [31:0] cpu_rd_data, pin_out, pin_oe, pin_pull_down, pin_in;
    logic [15:0] port_count, port_stamp, last_stamp;
    logic [2:0]  clk_sel;
    logic [31:0] exp_q[$];
    int          fails = 0, n_tests = 0, k;

    iopcb_port DUT (.core_clk, .reset, .port_enable, .dir_out, .link_enable, .narrow_claim, .cfg_write,
        .cfg_open_collector, .cfg_clk_sel, .cond_mode, .cond_value, .strobe_in_enable, .pull_write, .pull_value,
        .cb_ext_sel, .cb_div, .timed_arm, .timed_value, .cpu_wr_valid, .cpu_wr_ready, .cpu_wr_data, .cpu_rd_valid,
        .cpu_rd_ready, .cpu_rd_data, .port_count, .port_stamp, .timed_pending, .cond_event, .clk_sel,
        .open_collector, .pin_in, .pin_out, .pin_oe, .pin_pull_down, .ext_clk_in, .strobe_in, .strobe_out);

    iopcb_pins_model pins (.core_clk, .pin_out, .pin_oe, .pin_pull_down, .drive_en, .drive_val, .pull_up,
        .pin_in, .strobe_in, .ext_clk_in);

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t saw %h wanted %h", $time, seen, exp);
        end
    endtask

    task automatic guard();
        k++;
        if (k > 3000) begin
            fails++;
            $display("BAD %0t wait ran out", $time);
            stop_test();
        end
        @(negedge core_clk);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // leaves valid high so back-to-back words need no gap
    task automatic wr(input logic [31:0] d);
        cpu_wr_valid = 1'b1;
        cpu_wr_data = d;
        exp_q.push_back(d);
        k = 0;
        @(posedge core_clk);
        while (cpu_wr_ready !== 1'b1) begin
            guard();
            @(posedge core_clk);
        end
        @(negedge core_clk);
    endtask

    task automatic drain();
        k = 0;
        while (exp_q.size() != 0) guard();
        cyc(6);
    endtask

    task automatic cfg(input logic oc, input logic [2:0] sel);
        cfg_open_collector = oc;
        cfg_clk_sel = sel;
        cfg_write = 1'b1;
        cyc(1);
        cfg_write = 1'b0;
        cyc(1);
    endtask

    // watcher: a new stamp or a rising strobe in output mode marks a word on the pins
    // the strobe catches the first word, whose stamp can equal the reset stamp
    always @(posedge core_clk) begin
        if (!reset && dir_out && (port_stamp !== last_stamp || (strobe_out && !last_strobe))) begin
            check(32'(strobe_out), 32'h1);
            check(32'(port_count), 32'(port_stamp + 16'h0001));
            if (exp_q.size() == 0) check(pin_in, 32'hxxxx_xxxx);
            else check(pin_in, exp_q.pop_front());
        end
        if (!reset && cpu_rd_valid === 1'b1 && cpu_rd_ready) begin
            if (exp_q.size() == 0) check(cpu_rd_data, 32'hxxxx_xxxx);
            else check(cpu_rd_data, exp_q.pop_front());
        end
        last_stamp <= port_stamp;
        last_strobe <= strobe_out;
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h0ab6));
        cyc(6);
        check(pin_pull_down, 32'hffff_ffff);
        check(pin_oe, 32'h0);
        check({27'h0, clk_sel, open_collector, strobe_out}, 32'h0);
        check(32'(timed_pending), 32'h0);
        cyc(6);
        reset = 1'b0;
        port_enable = 1'b1;
        cyc(2);
        check(pin_pull_down, 32'h0);
        pull_value = $urandom();
        pull_write = 1'b1;
        cyc(1);
        pull_write = 1'b0;
        cyc(1);
        check(pin_pull_down, pull_value);
        $display("test pulls done");
        // link owns the pins, so nothing leaves the buffer while it fills
        for (int i = 0; i < 16; i++) wr($urandom());
        cpu_wr_valid = 1'b0;
        cyc(1);
        check(32'(cpu_wr_ready), 32'h0);
        check(pin_oe, 32'h0);
        link_enable = 1'b0;
        drain();
        check(32'(strobe_out), 32'h0);
        $display("test fill and drain done");
        tv = port_count + 16'h0030;
        timed_value = tv;
        timed_arm = 1'b1;
        cyc(1);
        timed_arm = 1'b0;
        check(32'(timed_pending), 32'h1);
        wr($urandom());
        cpu_wr_valid = 1'b0;
        k = 0;
        while (timed_pending !== 1'b0) guard();
        check(32'(port_stamp), 32'(tv));
        drain();
        $display("test timed done");
        cfg(1'b1, 3'h0);
        check(32'(open_collector), 32'h1);
        pull_up = 1'b1;
        v = $urandom();
        wr(v);
        cpu_wr_valid = 1'b0;
        drain();
        check(pin_oe, ~v);
        check(pin_out, 32'h0);
        pull_up = 1'b0;
        $display("test open collector done");
        cfg(1'b0, 3'h1);
        check(32'(clk_sel), 32'h1);
        c0 = port_count;
        pins.pulse_ext(10);
        cyc(8);
        check(32'(port_count), 32'(c0 + 16'h0005));
        cfg(1'b0, 3'h6);
        c0 = port_count;
        cyc(20);
        check(32'(port_count), 32'(c0));
        cfg(1'b0, 3'h0);
        c0 = port_count;
        cyc(20);
        check(32'(port_count), 32'(c0 + 16'h000a));
        $display("test clock blocks done");
        dir_out = 1'b0;
        cyc(1);
        check(32'(cpu_wr_ready), 32'h0);
        v = $urandom();
        narrow_claim = $urandom();
        drive_val = v;
        cond_value = v & ~narrow_claim;
        cond_mode = iopcb_pkg::COND_NE;
        drive_en = 1'b1;
        cyc(40);
        check(32'(cpu_rd_valid), 32'h0);
        cond_mode = iopcb_pkg::COND_EQ;
        k = 0;
        while (cond_event !== 1'b1) guard();
        cyc(60);
        drive_en = 1'b0;
        // let the filtered strobe fall before reading, so no extra word is sampled
        cyc(6);
        // sixteen buffered words plus the one held back by the full buffer
        for (int i = 0; i < 17; i++) exp_q.push_back(v & ~narrow_claim);
        cpu_rd_ready = 1'b1;
        k = 0;
        while (cpu_rd_valid !== 1'b0) guard();
        cpu_rd_ready = 1'b0;
        check(32'(exp_q.size()), 32'h0);
        $display("test input done");
        stop_test();
    end
endmodule // tb_top
